// ==== verilog/rsw_supervisor.sv ====
`timescale 1ns/100ps
`include "rsw_cfg.svh"
// ********************************************************
// Overview of operation
// - Hold reset under threshold, then timeout
// - Release reset pin when timeout ends
// - Open drain, drives only asserted level
// - Assert reset when supply goes low
// - Ignore supply dips up to 30 ns
// - Falling reset pin restarts the timeout
// - Manual reset held at least full timeout
// - Manual low pulses under 100 ns ignored
// - Only active-low variant takes manual reset
// - Memory disabled while reset is present
// - Abort bus on reset, refuse new traffic
// - No write start in reset, finish running
// - Write starts at stop, lasts 5 ms
// - During write, release data, no acknowledge
// ********************************************************
module rsw_supervisor #(
  parameter logic HIGH_VARIANT = 1'b0,
  parameter int unsigned TIMEOUT_CYC = `RSW_TIMEOUT_CYC,
  parameter int unsigned WRITE_CYC = `RSW_WRITE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic supplyLowRaw,
  input wire logic rstPinIn,
  input wire logic writeStopSeen,
  output logic rstPinOut,
  output logic rstPinOe,
  output logic busEnable,
  output logic busAbort,
  output logic writeBusy,
  output logic sdaRelease,
  output rsw_pkg::rsw_state_t supState
);
  import rsw_pkg::*;

  localparam int TIMEOUT_LAST = TIMEOUT_CYC - 1;
  localparam int WRITE_LAST = WRITE_CYC - 1;

  logic supplyLow;
  logic manualLow;
  logic manualLowQ;
  logic manualFall;
  logic wrStart;
  logic next_wrBusy;
  logic timeoutDone;
  logic writeDone;
  logic [25:0] timeCnt;
  logic [19:0] wrCnt;
  rsw_state_t state;
  rsw_state_t next_state;

  // ********************************************************
  // Input filters
  // ********************************************************
  // Supply comparator, dips up to the reject width are dropped
  rsw_glitch_filter #(
    .HOLD_CYC(`RSW_DIP_CYC + 1),
    .INVERT(1'b0)
  ) uDipFilter (
    .ref_clk(ref_clk),
    .reset(reset),
    .rawIn(supplyLowRaw),
    .filtOut(supplyLow)
  );

  // Reset pin sensed low, short glitches dropped
  rsw_glitch_filter #(
    .HOLD_CYC(`RSW_MANUAL_CYC + 1),
    .INVERT(1'b1)
  ) uManualFilter (
    .ref_clk(ref_clk),
    .reset(reset),
    .rawIn(rstPinIn),
    .filtOut(manualLow)
  );

  // Previous manual level for edge detection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      manualLowQ <= 1'b0;
    end else begin
      manualLowQ <= manualLow;
    end
  end

  // Edge only, own drive masked, active-low variant only
  assign manualFall = !HIGH_VARIANT && manualLow && !manualLowQ && !rstPinOe;

  // ********************************************************
  // Supervisor state machine
  // ********************************************************
  assign timeoutDone = (timeCnt == 26'(TIMEOUT_LAST));

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      SUP_UNDER: begin
        if (!supplyLow) begin
          next_state = SUP_TIMING;
        end
      end
      SUP_TIMING: begin
        if (supplyLow) begin
          next_state = SUP_UNDER;
        end else if (manualFall) begin
          next_state = SUP_TIMING;
        end else if (timeoutDone) begin
          next_state = SUP_IDLE;
        end
      end
      SUP_IDLE: begin
        if (supplyLow) begin
          next_state = SUP_UNDER;
        end else if (manualFall) begin
          next_state = SUP_TIMING;
        end
      end
      default: begin
        next_state = SUP_UNDER;
      end
    endcase
  end

  // State register, starts under threshold
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= SUP_UNDER;
    end else begin
      state <= next_state;
    end
  end

  // Timeout counter, restarted by a manual edge
  always_ff @(posedge ref_clk) begin
    if (reset || state != SUP_TIMING || manualFall) begin
      timeCnt <= 26'h0000000;
    end else begin
      timeCnt <= timeCnt + 26'h0000001;
    end
  end

  // ********************************************************
  // Reset pin driver
  // ********************************************************
  // Drives the asserted level only, released otherwise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rstPinOe <= `RSW_RST_PIN_OE;
      rstPinOut <= HIGH_VARIANT;
    end else begin
      rstPinOe <= (next_state != SUP_IDLE);
      rstPinOut <= HIGH_VARIANT;
    end
  end

  // State visible outside
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      supState <= SUP_UNDER;
    end else begin
      supState <= next_state;
    end
  end

  // ********************************************************
  // Internal write cycle
  // ********************************************************
  assign writeDone = (wrCnt == 20'(WRITE_LAST));
  assign wrStart = writeStopSeen && (state == SUP_IDLE) && !writeBusy;

  // Busy flag next value, runs on through reset
  always_comb begin
    next_wrBusy = writeBusy;
    if (wrStart) begin
      next_wrBusy = 1'b1;
    end else if (writeBusy && writeDone) begin
      next_wrBusy = 1'b0;
    end
  end

  // Busy flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      writeBusy <= 1'b0;
    end else begin
      writeBusy <= next_wrBusy;
    end
  end

  // Write duration counter
  always_ff @(posedge ref_clk) begin
    if (reset || !writeBusy) begin
      wrCnt <= 20'h00000;
    end else begin
      wrCnt <= wrCnt + 20'h00001;
    end
  end

  // ********************************************************
  // Bus gating
  // ********************************************************
  // Enable, abort pulse and data line release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busEnable <= `RSW_RST_BUS_EN;
      busAbort <= 1'b0;
      sdaRelease <= 1'b0;
    end else begin
      busEnable <= (next_state == SUP_IDLE) && !next_wrBusy;
      busAbort <= (state == SUP_IDLE) && (next_state != SUP_IDLE);
      sdaRelease <= next_wrBusy;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cbm @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_manual_edge;
    manualFall && !supplyLow;
  endsequence

  sequence s_write_start;
    wrStart;
  endsequence

  a_timeout_length: assert property (
    $rose(state == SUP_IDLE) |->
      $past(state) == SUP_TIMING && $past(timeCnt) == 26'(TIMEOUT_LAST))
    else $error("timeout ended at wrong count");

  a_pin_release: assert property (
    $fell(rstPinOe) |-> $past(state) == SUP_TIMING && state == SUP_IDLE)
    else $error("reset pin released outside timeout end");

  a_drive_level: assert property (
    rstPinOe |-> rstPinOut == HIGH_VARIANT)
    else $error("reset pin drives the wrong level");

  a_power_down: assert property (
    supplyLow |=> rstPinOe && state == SUP_UNDER)
    else $error("reset not asserted on low supply");

  a_manual_start: assert property (
    s_manual_edge |=> state == SUP_TIMING && timeCnt == 26'h0000000)
    else $error("manual edge did not restart timeout");

  a_manual_hold: assert property (
    s_manual_edge |=> rstPinOe [*8])
    else $error("manual reset not held");

  a_variant_only: assert property (
    HIGH_VARIANT |-> !manualFall)
    else $error("manual reset taken on active-high variant");

  a_bus_gated: assert property (
    (state != SUP_IDLE) |-> !busEnable)
    else $error("bus enabled during reset");

  a_abort_pulse: assert property (
    busAbort |-> $past(state) == SUP_IDLE && state != SUP_IDLE && !busEnable)
    else $error("abort pulse without reset entry");

  a_no_start: assert property (
    (writeStopSeen && state != SUP_IDLE && !writeBusy) |=> !writeBusy)
    else $error("write cycle started during reset");

  a_write_runs: assert property (
    s_write_start |=> writeBusy [*8])
    else $error("write cycle cut short");

  a_write_length: assert property (
    $fell(writeBusy) |-> $past(wrCnt) == 20'(WRITE_LAST))
    else $error("write cycle ended at wrong count");

  a_busy_release: assert property (
    writeBusy |-> sdaRelease && !busEnable)
    else $error("bus active during write cycle");

endmodule : rsw_supervisor

// ==== shared/rsw_cfg.svh ====
`ifndef RSW_CFG_SVH
`define RSW_CFG_SVH

// ********************************************************
// Clock rate
// ********************************************************
`define RSW_CLK_MHZ 200

// ********************************************************
// Printed times in their own units
// ********************************************************
`define RSW_TIMEOUT_MS 200
`define RSW_WRITE_CYCLE_MS 5
`define RSW_DIP_REJECT_NS 30
`define RSW_MANUAL_GLITCH_NS 100

// ********************************************************
// Cycle counts derived from the times
// ********************************************************
// Reset timeout, nominal
`define RSW_TIMEOUT_CYC (`RSW_TIMEOUT_MS * `RSW_CLK_MHZ * 1000)
// Write cycle duration, longest time rounds down
`define RSW_WRITE_CYC (`RSW_WRITE_CYCLE_MS * `RSW_CLK_MHZ * 1000)
// Supply dip reject width, longest time rounds down
`define RSW_DIP_CYC ((`RSW_DIP_REJECT_NS * `RSW_CLK_MHZ) / 1000)
// Manual glitch immunity, least time rounds up
`define RSW_MANUAL_CYC ((`RSW_MANUAL_GLITCH_NS * `RSW_CLK_MHZ + 999) / 1000)

// ********************************************************
// Reset values
// ********************************************************
`define RSW_RST_PIN_OE 1'b1
`define RSW_RST_BUS_EN 1'b0

`endif

// ==== shared/rsw_pkg.sv ====
package rsw_pkg;

  // Supervisor states
  typedef enum logic [1:0] {
    SUP_UNDER,
    SUP_TIMING,
    SUP_IDLE
  } rsw_state_t;

endpackage : rsw_pkg

// ==== verilog/rsw_glitch_filter.sv ====
`timescale 1ns/100ps
// ********************************************************
// Pin synchroniser and pulse width filter
// ********************************************************
module rsw_glitch_filter #(
  parameter int unsigned HOLD_CYC = 2,
  parameter logic INVERT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rawIn,
  output logic filtOut
);

  localparam int HOLD_LAST = HOLD_CYC - 1;

  logic syncA;
  logic syncB;
  logic level;
  logic [7:0] runCnt;

  // Two stage synchroniser
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end

  assign level = syncB ^ INVERT;

  // Run length of the active level
  always_ff @(posedge ref_clk) begin
    if (reset || !level) begin
      runCnt <= 8'h00;
    end else if (runCnt != 8'(HOLD_LAST)) begin
      runCnt <= runCnt + 8'h01;
    end
  end

  // Output only after a full run, drops at once
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filtOut <= 1'b0;
    end else begin
      filtOut <= level && (runCnt == 8'(HOLD_LAST));
    end
  end

  default clocking cbf @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_filter_run_length: assert property (
    $rose(filtOut) |-> $past(level) && ($past(runCnt) == 8'(HOLD_LAST)))
    else $error("filter output rose before a full run");

  a_filter_drop: assert property (
    !level |=> !filtOut)
    else $error("filter output stayed after level dropped");

endmodule : rsw_glitch_filter

// ==== testbench/rsw_pin_model.sv ====
`timescale 1ns/100ps
// ********************************************************
// Reset pin wire with pull resistor and push button
// ********************************************************
module rsw_pin_model #(
  parameter logic PULL = 1'b1
) (
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic pushLow,
  output logic rstPinIn
);
  // Device drive wins, then button, then pull level
  always_comb begin
    if (rstPinOe) begin
      rstPinIn = rstPinOut;
    end else if (pushLow) begin
      rstPinIn = 1'b0;
    end else begin
      rstPinIn = PULL;
    end
  end
endmodule : rsw_pin_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
// ********************************************************
// Bench top
// ********************************************************
module tb_top;
  import rsw_pkg::*;
  localparam int T = 200;
  localparam int W = 50;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic supplyLowRaw = 1'b0;
  logic writeStopSeen = 1'b0;
  logic pushLow = 1'b0;
  logic rstPinIn, rstPinOut, rstPinOe, busEnable, busAbort, writeBusy, sdaRelease;
  logic hiPinIn, hiPinOut, hiPinOe;
  int abortCnt = 0;
  int hiOeCnt = 0;
  rsw_state_t supState;
  int num_errors = 0;
  int checked = 0;
  int n;

  // Active-low variant and active-high variant
  rsw_supervisor #(.HIGH_VARIANT(1'b0), .TIMEOUT_CYC(T), .WRITE_CYC(W)) dut (
    .ref_clk(ref_clk), .reset(reset), .supplyLowRaw(supplyLowRaw),
    .rstPinIn(rstPinIn), .writeStopSeen(writeStopSeen), .rstPinOut(rstPinOut),
    .rstPinOe(rstPinOe), .busEnable(busEnable), .busAbort(busAbort),
    .writeBusy(writeBusy), .sdaRelease(sdaRelease), .supState(supState));
  rsw_supervisor #(.HIGH_VARIANT(1'b1), .TIMEOUT_CYC(T), .WRITE_CYC(W)) dutHigh (
    .ref_clk(ref_clk), .reset(reset), .supplyLowRaw(supplyLowRaw),
    .rstPinIn(hiPinIn), .writeStopSeen(1'b0), .rstPinOut(hiPinOut),
    .rstPinOe(hiPinOe), .busEnable(), .busAbort(), .writeBusy(),
    .sdaRelease(), .supState());
  rsw_pin_model #(.PULL(1'b1)) pinLow (.rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .pushLow(pushLow), .rstPinIn(rstPinIn));
  rsw_pin_model #(.PULL(1'b0)) pinHigh (.rstPinOut(hiPinOut), .rstPinOe(hiPinOe),
    .pushLow(pushLow), .rstPinIn(hiPinIn));

  // Clock
  always #2.5 ref_clk = ~ref_clk;

  // Counts of abort pulses and of high variant drive cycles
  always @(posedge ref_clk) begin
    if (busAbort === 1'b1) abortCnt <= abortCnt + 1;
    if (hiPinOe === 1'b1) hiOeCnt <= hiOeCnt + 1;
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic chk1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  task automatic chkInt(input string name, input int exp, input int got);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chkInt

  task automatic chkState(input string name, input rsw_state_t exp, input rsw_state_t got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chkState

  // Bounded wait for pin drive level
  task automatic waitOe(input logic val, input int lim, output int cnt);
    cnt = 0;
    while (rstPinOe !== val && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask : waitOe

  // Bounded count of write busy cycles
  task automatic busyLen(output int cnt);
    cnt = 0;
    while (writeBusy === 1'b1 && cnt < 1000) begin
      cnt++;
      @(negedge ref_clk);
    end
  endtask : busyLen

  task automatic stopPulse;
    @(posedge ref_clk);
    writeStopSeen <= 1'b1;
    @(posedge ref_clk);
    writeStopSeen <= 1'b0;
    @(negedge ref_clk);
  endtask : stopPulse

  task automatic pushFor(input int len);
    @(posedge ref_clk);
    pushLow <= 1'b1;
    repeat (len) @(posedge ref_clk);
    pushLow <= 1'b0;
  endtask : pushFor

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_powerup;
    @(negedge ref_clk);
    chk1("oe in reset", 1'b1, rstPinOe);
    chk1("low drive level", 1'b0, rstPinOut);
    chk1("high drive level", 1'b1, hiPinOut);
    @(posedge ref_clk);
    reset <= 1'b0;
    waitOe(1'b0, 1000, n);
    chk1("timeout length", 1'b1, n >= T && n <= T + 5);
    chk1("pin pulled up", 1'b1, rstPinIn);
    chk1("high pin pulled down", 1'b0, hiPinIn);
    chkState("state idle", SUP_IDLE, supState);
    @(negedge ref_clk);
    chk1("bus enabled", 1'b1, busEnable);
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_dip;
    int a0;
    @(posedge ref_clk);
    supplyLowRaw <= 1'b1;
    repeat (6) @(posedge ref_clk);
    supplyLowRaw <= 1'b0;
    repeat (20) @(negedge ref_clk);
    chk1("short dip", 1'b0, rstPinOe);
    chk1("high variant idle", 1'b0, hiPinOe);
    a0 = abortCnt;
    @(posedge ref_clk);
    supplyLowRaw <= 1'b1;
    waitOe(1'b1, 30, n);
    chk1("power down delay", 1'b1, n >= 8 && n <= 14);
    repeat (2) @(negedge ref_clk);
    chkInt("abort pulse", a0 + 1, abortCnt);
    chk1("bus refused", 1'b0, busEnable);
    chkState("state under", SUP_UNDER, supState);
    chk1("high variant oe", 1'b1, hiPinOe);
    repeat (T + 40) @(negedge ref_clk);
    chk1("held while low", 1'b1, rstPinOe);
    @(posedge ref_clk);
    supplyLowRaw <= 1'b0;
    waitOe(1'b0, 1000, n);
    chk1("recovery timeout", 1'b1, n >= T && n <= T + 8);
    $display("test dip done");
  endtask : t_dip

  task automatic t_manual;
    int h0;
    pushFor(20);
    repeat (30) @(negedge ref_clk);
    chk1("short press", 1'b0, rstPinOe);
    h0 = hiOeCnt;
    @(posedge ref_clk);
    pushLow <= 1'b1;
    waitOe(1'b1, 40, n);
    chk1("press delay", 1'b1, n >= 21 && n <= 28);
    repeat (5) @(posedge ref_clk);
    pushLow <= 1'b0;
    waitOe(1'b0, 1000, n);
    chk1("manual hold", 1'b1, n >= T - 8 && n <= T);
    chkInt("high variant no manual", h0, hiOeCnt);
    $display("test manual done");
  endtask : t_manual

  task automatic t_write;
    stopPulse();
    chk1("busy after stop", 1'b1, writeBusy);
    chk1("data released", 1'b1, sdaRelease);
    chk1("bus off in write", 1'b0, busEnable);
    busyLen(n);
    chkInt("write length", W, n);
    chk1("bus back", 1'b1, busEnable);
    stopPulse();
    @(posedge ref_clk);
    supplyLowRaw <= 1'b1;
    @(negedge ref_clk);
    // Counting starts one cycle into the busy run
    busyLen(n);
    chkInt("write through reset", W - 1, n);
    chk1("reset active", 1'b1, rstPinOe);
    stopPulse();
    chk1("no write in reset", 1'b0, writeBusy);
    chk1("bus off in reset", 1'b0, busEnable);
    @(posedge ref_clk);
    supplyLowRaw <= 1'b0;
    waitOe(1'b0, 1000, n);
    @(negedge ref_clk);
    chk1("bus after release", 1'b1, busEnable);
    $display("test write done");
  endtask : t_write

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    fork
      begin
        t_powerup();
        t_dip();
        t_manual();
        t_write();
      end
      begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("ERROR run limit expected done seen running");
      end
    join_any
    tally_and_finish();
  end
endmodule : tb_top
